// ===== design/ppi_flag_bank.sv
// Sticky flags, set on event pulse and cleared by a read
`timescale 1ns/1ps
`default_nettype none
module ppi_flag_bank #(
    parameter int N = 7
) (
    input  wire logic         core_clk, // Block clock
    input  wire logic         reset,    // Synchronous reset, active high
    input  wire logic [N-1:0] set,      // Event pulses
    input  wire logic         clear,    // Clear all flags
    output logic      [N-1:0] flags     // Sticky flags
);
    logic [N-1:0] next_flags;

    // Set wins over clear so no event is lost in a read cycle
    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_flags[i] = set[i] | (flags[i] & ~clear);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end
endmodule : ppi_flag_bank
`default_nettype wire

// ===== design/ppi_pkg.sv
// Package of constants for the port PHY event and status block
package ppi_pkg;
    // ****************************************************************
    // Register map (index times four gives the byte address)
    // ****************************************************************
    localparam logic [7:0]  IDX_SOURCE       = 8'h1d;
    localparam logic [7:0]  IDX_MASK         = 8'h1e;
    localparam logic [7:0]  IDX_SPECIAL      = 8'h1f;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h20;
    localparam logic [7:0]  IDX_IRQ_MASK     = 8'h21;
    localparam logic [11:0] ADDR_SOURCE      = {2'h0, IDX_SOURCE, 2'h0};
    localparam logic [11:0] ADDR_MASK        = {2'h0, IDX_MASK, 2'h0};
    localparam logic [11:0] ADDR_SPECIAL     = {2'h0, IDX_SPECIAL, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STATUS  = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};
    // ****************************************************************
    // Field layouts and reset values
    // ****************************************************************
    localparam int          EVT_LSB          = 1;
    localparam int          EVT_MSB          = 7;
    localparam int          EVT_N            = 7;
    localparam logic [15:0] EVT_FIELD        = 16'h00fe;
    localparam logic [15:0] MASK_RESET       = 16'h0000;
    localparam int          DONE_BIT         = 12;
    localparam int          FILL_LSB         = 5;
    localparam int          FILL_MSB         = 11;
    localparam logic [6:0]  FILL_RESET       = 7'h02;
    localparam int          SPEED_LSB        = 2;
    localparam int          SPEED_MSB        = 4;
    localparam logic [2:0]  SPEED_RESET_MII  = 3'h2;
    localparam logic [2:0]  SPEED_RESET_INT  = 3'h0;
    localparam logic [1:0]  LOW_RESET        = 2'h0;
    // Interrupt status bits of the wrapper register
    localparam int          IRQ_N            = 2;
    localparam int          IRQ_EVT_BIT      = 0;
    localparam int          IRQ_SPEED_BIT    = 1;
endpackage : ppi_pkg

// ===== design/ppi_port_irq.sv
// Port PHY event flags, mask, speed status and APB slave
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Enabled event sets sticky flag
// - Source flags ignore writes
// - Reading source flags clears them
// - Bit 7 latches energy detected
// - Bit 6 latches negotiation done
// - Bit 5 latches remote fault
// - Bit 4 latches link down
// - Bit 3 latches partner acknowledge
// - Bit 2 latches parallel detection fault
// - Bit 1 latches page received
// - Mask bits 7..1 enable, reset zero
// - Bit 12 shows negotiation complete
// - Bits 11..5 reset to 0000010b, writable
// - Bits 4..2 report speed and duplex
// - Speed resets 010b with MII, else 000b
module ppi_port_irq (
    input  wire logic        core_clk,             // 25 MHz block clock
    input  wire logic        reset,                // Synchronous reset, active high
    input  wire logic        psel,                 // APB select
    input  wire logic        penable,              // APB access phase
    input  wire logic        pwrite,               // APB write
    input  wire logic [11:0] paddr,                // APB byte address
    input  wire logic [31:0] pwdata,               // APB write data
    output logic      [31:0] prdata,               // APB read data
    output logic             pready,               // APB ready
    output logic             pslverr,              // APB error, unmapped address
    input  wire logic        energy_detected,      // Energy detected level
    input  wire logic        neg_done_evt,         // Negotiation finished
    input  wire logic        remote_fault_evt,     // Remote fault seen
    input  wire logic        link_up,              // Link status level
    input  wire logic        partner_ack_evt,      // Partner acknowledge
    input  wire logic        parallel_fault_evt,   // Parallel detection fault
    input  wire logic        page_received_evt,    // Page received
    input  wire logic        neg_complete,         // Negotiation complete level
    input  wire logic [2:0]  speed_duplex,         // Resolved speed and duplex
    input  wire logic        speed_valid,          // Resolved code is current
    input  wire logic        ext_mii_mode,         // Any external MII mode
    output logic             phy_irq,              // Port PHY interrupt request
    output logic             irq                   // Wrapper interrupt, level
);
    // ****************************************************************
    // Event detection and sticky flags
    // ****************************************************************
    logic [ppi_pkg::EVT_N-1:0] evt_level;
    logic [ppi_pkg::EVT_N-1:0] evt_rise;
    logic [ppi_pkg::EVT_N-1:0] evt_set;
    logic [ppi_pkg::EVT_N-1:0] src_flags;
    logic [ppi_pkg::EVT_N-1:0] evt_mask;
    logic [ppi_pkg::EVT_N-1:0] next_evt_mask;
    logic                      src_read;

    // Index i maps to register bit i+1; link down is link status falling
    assign evt_level = {energy_detected,
                        neg_done_evt,
                        remote_fault_evt,
                        ~link_up,
                        partner_ack_evt,
                        parallel_fault_evt,
                        page_received_evt};

    ppi_rise_det #(
        .N        (ppi_pkg::EVT_N)
    ) u_rise (
        .core_clk (core_clk),
        .reset    (reset),
        .level    (evt_level),
        .rise     (evt_rise)
    );

    // Masked events never latch
    assign evt_set = evt_rise & evt_mask;

    ppi_flag_bank #(
        .N        (ppi_pkg::EVT_N)
    ) u_flags (
        .core_clk (core_clk),
        .reset    (reset),
        .set      (evt_set),
        .clear    (src_read),
        .flags    (src_flags)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit_src;
    logic        hit_mask;
    logic        hit_spec;
    logic        hit_ists;
    logic        hit_imsk;
    logic        mapped;

    // Zero-wait slave: access completes in the first access cycle
    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    // Read side effects sit on the setup edge, where the read word is captured;
    // clearing one cycle later would drop an event that lands in between
    assign rd       = psel & ~penable & ~pwrite;
    assign hit_src  = (paddr == ppi_pkg::ADDR_SOURCE);
    assign hit_mask = (paddr == ppi_pkg::ADDR_MASK);
    assign hit_spec = (paddr == ppi_pkg::ADDR_SPECIAL);
    assign hit_ists = (paddr == ppi_pkg::ADDR_IRQ_STATUS);
    assign hit_imsk = (paddr == ppi_pkg::ADDR_IRQ_MASK);
    assign mapped   = hit_src | hit_mask | hit_spec | hit_ists | hit_imsk;
    assign src_read = rd & hit_src;

    // ****************************************************************
    // Mask and special status registers
    // ****************************************************************
    logic [6:0]  fill;
    logic [6:0]  next_fill;
    logic [1:0]  low_bits;
    logic [1:0]  next_low_bits;
    logic [2:0]  speed;
    logic [2:0]  next_speed;
    logic        done;
    logic        next_done;
    logic        boot;
    logic        next_boot;

    // Writes to the source register fall through: no store for it
    always_comb begin
        next_evt_mask = evt_mask;
        next_fill     = fill;
        next_low_bits = low_bits;
        if (wr && hit_mask) begin
            next_evt_mask = pwdata[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB];
        end
        if (wr && hit_spec) begin
            next_fill     = pwdata[ppi_pkg::FILL_MSB:ppi_pkg::FILL_LSB];
            next_low_bits = pwdata[1:0];
        end
    end

    // Speed holds its strap default until the PHY resolves a code
    always_comb begin
        next_boot  = 1'b0;
        next_done  = neg_complete;
        next_speed = speed;
        if (boot) begin
            next_speed = ext_mii_mode ? ppi_pkg::SPEED_RESET_MII : ppi_pkg::SPEED_RESET_INT;
        end else if (speed_valid) begin
            next_speed = speed_duplex;
        end
    end

    // Strap is caught one cycle after reset, never under it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            evt_mask <= ppi_pkg::MASK_RESET[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB];
            fill     <= ppi_pkg::FILL_RESET;
            low_bits <= ppi_pkg::LOW_RESET;
            speed    <= ppi_pkg::SPEED_RESET_INT;
            done     <= 1'b0;
            boot     <= 1'b1;
        end else begin
            evt_mask <= next_evt_mask;
            fill     <= next_fill;
            low_bits <= next_low_bits;
            speed    <= next_speed;
            done     <= next_done;
            boot     <= next_boot;
        end
    end

    // ****************************************************************
    // Wrapper interrupt status and mask
    // ****************************************************************
    logic [ppi_pkg::IRQ_N-1:0] ists;
    logic [ppi_pkg::IRQ_N-1:0] next_ists;
    logic [ppi_pkg::IRQ_N-1:0] imsk;
    logic [ppi_pkg::IRQ_N-1:0] next_imsk;
    logic [ppi_pkg::IRQ_N-1:0] ists_evt;
    logic                      next_phy_irq;
    logic                      next_irq;

    assign ists_evt[ppi_pkg::IRQ_EVT_BIT]   = |evt_set;
    assign ists_evt[ppi_pkg::IRQ_SPEED_BIT] = ~boot & speed_valid & (speed_duplex != speed);

    // Read clears, but a new event in the same cycle wins
    always_comb begin
        next_ists = ists_evt | (ists & ~{ppi_pkg::IRQ_N{rd & hit_ists}});
        next_imsk = imsk;
        if (wr && hit_imsk) begin
            next_imsk = pwdata[ppi_pkg::IRQ_N-1:0];
        end
        next_phy_irq = |(next_flags_view() & next_evt_mask);
        next_irq     = |(next_ists & next_imsk);
    end

    // Flags as they will be after this edge, so the request tracks them
    function automatic logic [ppi_pkg::EVT_N-1:0] next_flags_view();
        next_flags_view = evt_set | (src_flags & ~{ppi_pkg::EVT_N{src_read}});
    endfunction : next_flags_view

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ists    <= '0;
            imsk    <= '0;
            phy_irq <= 1'b0;
            irq     <= 1'b0;
        end else begin
            ists    <= next_ists;
            imsk    <= next_imsk;
            phy_irq <= next_phy_irq;
            irq     <= next_irq;
        end
    end

    // ****************************************************************
    // APB read data and response
    // ****************************************************************
    logic [31:0] rd_word;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // Reserved bits read zero; answer registered so outputs come from flops
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (1'b1)
            hit_src:  rd_word[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB] = src_flags;
            hit_mask: rd_word[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB] = evt_mask;
            hit_spec: begin
                rd_word[ppi_pkg::DONE_BIT]                      = done;
                rd_word[ppi_pkg::FILL_MSB:ppi_pkg::FILL_LSB]    = fill;
                rd_word[ppi_pkg::SPEED_MSB:ppi_pkg::SPEED_LSB]  = speed;
                rd_word[1:0]                                    = low_bits;
            end
            hit_ists: rd_word[ppi_pkg::IRQ_N-1:0] = ists;
            hit_imsk: rd_word[ppi_pkg::IRQ_N-1:0] = imsk;
            default:  rd_word = 32'h0000_0000;
        endcase
        next_pready  = psel & ~penable;
        next_pslverr = psel & ~penable & ~mapped;
        next_prdata  = (psel & ~penable & ~pwrite) ? rd_word : 32'h0000_0000;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence src_read_s;
        psel && !penable && !pwrite && paddr == ppi_pkg::ADDR_SOURCE;
    endsequence

    // Latch, mask and clear behaviour of the source flags; request tracking, reset values, speed strap and done bit
    flag_latch_a: assert property (@(posedge core_clk) disable iff (reset)
        evt_set[0] |=> src_flags[0])
        else $error("enabled page event did not latch");
    masked_no_set_a: assert property (@(posedge core_clk) disable iff (reset)
        (!evt_mask[6] && !src_flags[6] && !src_read) |=> !src_flags[6])
        else $error("masked energy event latched");
    read_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        (src_read_s ##0 evt_set == '0) |=> src_flags == '0)
        else $error("source read did not clear flags");
    write_keep_a: assert property (@(posedge core_clk) disable iff (reset)
        (wr && hit_src && evt_set == '0) |=> $stable(src_flags))
        else $error("write altered source flags");
    link_down_a: assert property (@(posedge core_clk) disable iff (reset)
        (!$past(reset) && $fell(link_up) && evt_mask[3] && !src_read) |=> src_flags[3])
        else $error("link down did not latch");
    irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
        phy_irq == |(src_flags & evt_mask))
        else $error("phy request does not track flags");
    speed_strap_a: assert property (@(posedge core_clk)
        $fell(reset) ##0 !speed_valid ##1 !speed_valid |->
        speed == ($past(ext_mii_mode) ? ppi_pkg::SPEED_RESET_MII : ppi_pkg::SPEED_RESET_INT))
        else $error("speed reset value wrong");
    done_track_a: assert property (@(posedge core_clk) disable iff (reset)
        neg_complete[*2] |-> done)
        else $error("done bit does not follow negotiation");
    fill_reset_a: assert property (@(posedge core_clk)
        $fell(reset) |-> fill == ppi_pkg::FILL_RESET && low_bits == ppi_pkg::LOW_RESET)
        else $error("fill field reset wrong");
    reset_out_a: assert property (@(posedge core_clk)
        $fell(reset) |-> !phy_irq && !irq && evt_mask == '0 && src_flags == '0)
        else $error("reset left request, mask or flags set");
    mask_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        (evt_rise[0] && !evt_mask[0] && !src_flags[0]) |=> !src_flags[0])
        else $error("masked page event latched");

    // Read words: captured on the setup edge, reserved bits zero
    sequence flags_read_s;
        (rd && hit_src) ##1 pready;
    endsequence

    read_data_a: assert property (@(posedge core_clk) disable iff (reset)
        flags_read_s |-> prdata[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB] == $past(src_flags)
            && (prdata & ~{16'h0000, ppi_pkg::EVT_FIELD}) == '0)
        else $error("source read word wrong");
    mask_read_a: assert property (@(posedge core_clk) disable iff (reset)
        (rd && hit_mask) |=> prdata[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB] == $past(evt_mask)
            && (prdata & ~{16'h0000, ppi_pkg::EVT_FIELD}) == '0)
        else $error("mask read word wrong");
    spec_read_a: assert property (@(posedge core_clk) disable iff (reset)
        (rd && hit_spec) |=> prdata[ppi_pkg::SPEED_MSB:ppi_pkg::SPEED_LSB] == $past(speed)
            && prdata[31:ppi_pkg::DONE_BIT+1] == '0)
        else $error("special read word wrong");
    unmapped_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        (rd && !mapped) |=> pslverr && prdata == '0)
        else $error("unmapped read not refused");

    // Register writes and status tracking
    mask_write_a: assert property (@(posedge core_clk) disable iff (reset)
        (wr && hit_mask) |=> evt_mask == $past(pwdata[ppi_pkg::EVT_MSB:ppi_pkg::EVT_LSB]))
        else $error("mask write not stored");
    fill_write_a: assert property (@(posedge core_clk) disable iff (reset)
        (wr && hit_spec) |=> fill == $past(pwdata[ppi_pkg::FILL_MSB:ppi_pkg::FILL_LSB]))
        else $error("fill write not stored");
    speed_load_a: assert property (@(posedge core_clk) disable iff (reset)
        (!boot && speed_valid) |=> speed == $past(speed_duplex))
        else $error("speed code not loaded");
    speed_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (!boot && !speed_valid) |=> $stable(speed))
        else $error("speed changed without a code");
    done_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        !neg_complete |=> !done)
        else $error("done bit set without negotiation");

    // Energy event, built from its two steps
    sequence energy_rise_s;
        !$past(reset) && !$past(energy_detected) && energy_detected && evt_mask[6];
    endsequence
    sequence energy_latched_s;
        ##1 src_flags[6];
    endsequence

    energy_latch_a: assert property (@(posedge core_clk) disable iff (reset)
        energy_rise_s |-> energy_latched_s)
        else $error("energy event did not latch");
endmodule : ppi_port_irq
`default_nettype wire

// ===== design/ppi_rise_det.sv
// Rising edge detector for a group of event levels
`timescale 1ns/1ps
`default_nettype none
module ppi_rise_det #(
    parameter int N = 7
) (
    input  wire logic         core_clk, // Block clock
    input  wire logic         reset,    // Synchronous reset, active high
    input  wire logic [N-1:0] level,    // Event levels
    output logic      [N-1:0] rise      // One-cycle pulse on each rise
);
    logic [N-1:0] prev;
    logic [N-1:0] next_prev;

    // Next value of the previous-level copy
    always_comb begin
        next_prev = level;
    end

    // Register; reset to high so a level already up is not an event
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev <= '1;
        end else begin
            prev <= next_prev;
        end
    end

    assign rise = level & ~prev;
endmodule : ppi_rise_det
`default_nettype wire

// ===== tb/ppi_port_irq_tb.sv
// Self-checking testbench for the port PHY event and status block
`timescale 1ns/1ps
`default_nettype none
module ppi_port_irq_tb;
    // ****************************************************************
    // Stimulus, observed outputs and bookkeeping
    // ****************************************************************
    logic        core_clk     = 1'b0;
    logic        reset        = 1'b1;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0;
    logic [7:0]  ev           = 8'h00;   // Event levels, bit n feeds flag n
    logic        neg_complete = 1'b0;
    logic [2:0]  speed_duplex = 3'h0;
    logic        speed_valid  = 1'b0;
    logic        ext_mii_mode = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        phy_irq;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          n_fail       = 0;
    int          n_compared   = 0;
    int          cycles       = 0;

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    // Link status is the inverse of ev[4], so a rise of ev[4] is a link drop
    ppi_port_irq u_ppi_port_irq (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .energy_detected(ev[7]), .neg_done_evt(ev[6]), .remote_fault_evt(ev[5]),
        .link_up(~ev[4]), .partner_ack_evt(ev[3]), .parallel_fault_evt(ev[2]),
        .page_received_evt(ev[1]), .neg_complete(neg_complete), .speed_duplex(speed_duplex),
        .speed_valid(speed_valid), .ext_mii_mode(ext_mii_mode), .phy_irq(phy_irq), .irq(irq)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; waits on pready with no assumed latency
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Reset high for six edges; called at time zero or at an edge
    task automatic do_reset(input logic mii);
        reset        <= 1'b1;
        ext_mii_mode <= mii;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    // Raise a group of event levels for two cycles, then drop them
    task automatic pulse(input logic [7:0] bits);
        @(posedge core_clk);
        ev <= bits;
        repeat (2) @(posedge core_clk);
        ev <= 8'h00;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_values();
        do_reset(1'b0);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        check("source after reset", rd, 32'h0);
        apb(1'b0, ppi_pkg::ADDR_MASK, 32'h0);
        check("mask after reset", rd, 32'h0);
        apb(1'b0, ppi_pkg::ADDR_SPECIAL, 32'h0);
        check("special internal reset", rd, 32'h0000_0040);
        do_reset(1'b1);
        apb(1'b0, ppi_pkg::ADDR_SPECIAL, 32'h0);
        check("special mii reset", rd, 32'h0000_0048);
        check("mapped read err", {31'h0, err}, 32'h0);
    endtask : t_reset_values

    // Every source sets its own bit; two at once; read clears all
    task automatic t_each_event();
        apb(1'b1, ppi_pkg::ADDR_MASK, 32'hffff_ffff);
        apb(1'b0, ppi_pkg::ADDR_MASK, 32'h0);
        check("mask readback", rd, 32'h0000_00fe);
        for (int b = 1; b <= 7; b++) begin
            pulse(8'h01 << b);
            check("irq on event", {31'h0, phy_irq}, 32'h1);
            apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
            check("source flag bit", rd, 32'h1 << b);
            apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
            check("source after read", rd, 32'h0);
            check("irq after read", {31'h0, phy_irq}, 32'h0);
        end
        pulse(8'h82);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        check("two sources", rd, 32'h0000_0082);
    endtask : t_each_event

    // Masked source is not latched; writes leave flags alone; mask gates request
    task automatic t_mask_and_write();
        apb(1'b1, ppi_pkg::ADDR_MASK, 32'h0000_0020);
        pulse(8'h80);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        check("masked source", rd, 32'h0);
        check("masked irq", {31'h0, phy_irq}, 32'h0);
        pulse(8'h20);
        apb(1'b1, ppi_pkg::ADDR_SOURCE, 32'h0);
        apb(1'b1, ppi_pkg::ADDR_MASK, 32'h0);
        @(posedge core_clk);
        check("irq mask off", {31'h0, phy_irq}, 32'h0);
        apb(1'b1, ppi_pkg::ADDR_MASK, 32'h0000_0020);
        @(posedge core_clk);
        check("irq mask on", {31'h0, phy_irq}, 32'h1);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        check("source after write", rd, 32'h0000_0020);
        // An event rising on a read's setup edge must outlive that read
        fork
            apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
            begin
                @(posedge core_clk);
                ev <= 8'h20;
            end
        join
        ev <= 8'h00;
        check("source race read", rd, 32'h0);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        check("source race kept", rd, 32'h0000_0020);
    endtask : t_mask_and_write

    // Speed codes, completion bit and a special write whose fill field equals its reset value
    task automatic t_speed_status();
        logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
        foreach (codes[i]) begin
            @(posedge core_clk);
            speed_duplex <= codes[i];
            speed_valid  <= 1'b1;
            @(posedge core_clk);
            speed_valid  <= 1'b0;
            apb(1'b0, ppi_pkg::ADDR_SPECIAL, 32'h0);
            check("speed code", {29'h0, rd[4:2]}, {29'h0, codes[i]});
        end
        neg_complete <= 1'b1;
        apb(1'b1, ppi_pkg::ADDR_SPECIAL, 32'h0000_0043);
        apb(1'b0, ppi_pkg::ADDR_SPECIAL, 32'h0);
        check("special done set", rd & 32'h0000_1fe3, 32'h0000_1043);
        neg_complete <= 1'b0;
        repeat (2) @(posedge core_clk);
        apb(1'b0, ppi_pkg::ADDR_SPECIAL, 32'h0);
        check("special done clear", {31'h0, rd[12]}, 32'h0);
    endtask : t_speed_status

    // Wrapper interrupt raise, mask, clear and an unmapped access
    task automatic t_wrapper();
        apb(1'b0, ppi_pkg::ADDR_IRQ_STATUS, 32'h0);
        apb(1'b1, ppi_pkg::ADDR_IRQ_MASK, 32'h0);
        pulse(8'h20);
        check("wrapper masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ppi_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        @(posedge core_clk);
        check("wrapper raised", {31'h0, irq}, 32'h1);
        apb(1'b0, ppi_pkg::ADDR_SOURCE, 32'h0);
        apb(1'b0, ppi_pkg::ADDR_IRQ_STATUS, 32'h0);
        check("wrapper status", {31'h0, rd[0]}, 32'h1);
        repeat (2) @(posedge core_clk);
        check("wrapper cleared", {31'h0, irq}, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask : t_wrapper

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    initial begin
        t_reset_values();
        t_each_event();
        t_mask_and_write();
        t_speed_status();
        t_wrapper();
        report_and_stop();
    end

    // The whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            report_and_stop();
        end
    end
endmodule : ppi_port_irq_tb
`default_nettype wire
